//--- src/pwr_pkg.sv
// constants and types shared by the power-down controller
package pwr_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_SYSCTL = 4'h0;
  localparam logic [3:0] OFS_MSTHIGH = 4'h4;
  localparam logic [3:0] OFS_MSTLOW = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // ----------------------------------------------------------------
  // reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] SYSCTL_RST = 8'h09;
  localparam logic [7:0] MSTHIGH_RST = 8'h78;
  localparam logic [7:0] MSTLOW_RST = 8'h00;
  localparam logic [7:0] MSTHIGH_ONES = 8'h78;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_HW_STANDBY_PIN_SEL = 7;
  localparam int BIT_SETTLE_HI = 6;
  localparam int BIT_SETTLE_LO = 4;
  localparam int BIT_HW_STANDBY_PIN_OE = 1;
  localparam int BIT_CLK_STOP = 7;
  localparam int BIT_SER1 = 1;
  localparam int BIT_SER0 = 0;
  localparam int BIT_TMR16 = 4;
  localparam int BIT_TMR8_01 = 3;
  localparam int BIT_TMR8_23 = 2;
  localparam int BIT_ADC = 0;
  // ----------------------------------------------------------------
  // settling waits in states (one state = one clk cycle)
  // ----------------------------------------------------------------
  localparam int SETTLE_W = 19;
  localparam logic [18:0] WAIT_8192 = 19'h02000;
  localparam logic [18:0] WAIT_16384 = 19'h04000;
  localparam logic [18:0] WAIT_32768 = 19'h08000;
  localparam logic [18:0] WAIT_65536 = 19'h10000;
  localparam logic [18:0] WAIT_131072 = 19'h20000;
  localparam logic [18:0] WAIT_262144 = 19'h40000;
  localparam logic [18:0] WAIT_1024 = 19'h00400;
  // ----------------------------------------------------------------
  // bus answers and power states
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_SWSTBY, ST_SETTLE, ST_HWSTBY} pwr_state_t;
endpackage

//--- src/power_down_ctrl.sv
// power-down controller: sleep, software standby, module standby
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module power_down_ctrl #(
  parameter logic [18:0] WAIT_A = pwr_pkg::WAIT_8192,
  parameter logic [18:0] WAIT_B = pwr_pkg::WAIT_16384,
  parameter logic [18:0] WAIT_C = pwr_pkg::WAIT_32768,
  parameter logic [18:0] WAIT_D = pwr_pkg::WAIT_65536,
  parameter logic [18:0] WAIT_E = pwr_pkg::WAIT_131072,
  parameter logic [18:0] WAIT_F = pwr_pkg::WAIT_262144,
  parameter logic [18:0] WAIT_G = pwr_pkg::WAIT_1024
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic sleepExec,
  input wire logic nmiReq,
  input wire logic irqReq,
  input wire logic irqPeriphEnable,
  input wire logic irqMasked,
  input wire logic [2:0] extIrqReq,
  input wire logic [2:0] extIrqEnable,
  input wire logic resetPinN,
  input wire logic hwStandbyPinN,
  output logic cpuHalt,
  output logic oscRun,
  output logic chipClockRun,
  output logic periphReset,
  output logic irqHandleStart,
  output logic chipResetHold,
  output logic hwStandby,
  output logic sysClockOutEnable,
  output logic addrBusOe,
  output logic busCtrlOe,
  output logic busCtrlForceHigh,
  output logic serial0Standby,
  output logic serial1Standby,
  output logic timer16Standby,
  output logic timer8Ch01Standby,
  output logic timer8Ch23Standby,
  output logic adcStandby
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] resSync;
  logic [2:0] hwsSync;
  logic resLevel;
  logic hwsLevel;
  always_ff @(posedge clk) begin
    if (rst) begin
      resSync <= 3'h7;
      hwsSync <= 3'h7;
    end else begin
      resSync <= {resSync[1:0], resetPinN};
      hwsSync <= {hwsSync[1:0], hwStandbyPinN};
    end
  end
  // a change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      resLevel <= 1'b1;
      hwsLevel <= 1'b1;
    end else begin
      if (resSync[1] == resSync[2]) begin
        resLevel <= resSync[2];
      end
      if (hwsSync[1] == hwsSync[2]) begin
        hwsLevel <= hwsSync[2];
      end
    end
  end
  logic pinReset;
  logic pinHwStby;
  assign pinReset = !resLevel;
  assign pinHwStby = !hwsLevel;
  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic awHeld;
  logic wHeld;
  logic [3:0] awAddrHeld;
  logic [7:0] wByte;
  logic wLane0;
  logic doWrite;
  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign arready = !rvalid;
  assign doWrite = awHeld && wHeld && !bvalid;

  function automatic logic isMapped(input logic [3:0] a);
    isMapped = (a == pwr_pkg::OFS_SYSCTL) || (a == pwr_pkg::OFS_MSTHIGH) ||
               (a == pwr_pkg::OFS_MSTLOW) || (a == pwr_pkg::OFS_STATUS);
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrHeld <= 4'h0;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= pwr_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrHeld <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wByte <= wdata[7:0];
        wLane0 <= wstrb[0];
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= isMapped(awAddrHeld) ? pwr_pkg::RESP_OKAY : pwr_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] sysCtl;
  logic [7:0] mstHigh;
  logic [7:0] mstLow;
  logic regInit;
  logic wrLegal;
  pwr_pkg::pwr_state_t state;
  pwr_pkg::pwr_state_t next_state;
  // chip reset and hardware standby reinitialise; software standby keeps
  assign regInit = pinReset || pinHwStby;
  assign wrLegal = doWrite && wLane0;
  always_ff @(posedge clk) begin
    if (rst) begin
      sysCtl <= pwr_pkg::SYSCTL_RST;
      mstHigh <= pwr_pkg::MSTHIGH_RST;
      mstLow <= pwr_pkg::MSTLOW_RST;
    end else if (regInit) begin
      sysCtl <= pwr_pkg::SYSCTL_RST;
      mstHigh <= pwr_pkg::MSTHIGH_RST;
      mstLow <= pwr_pkg::MSTLOW_RST;
    end else if (wrLegal) begin
      // standby select changes only through this write or a chip reset/hardware standby reinit, never on wake
      if (awAddrHeld == pwr_pkg::OFS_SYSCTL) begin
        sysCtl <= wByte;
      end
      if (awAddrHeld == pwr_pkg::OFS_MSTHIGH) begin
        mstHigh <= wByte | pwr_pkg::MSTHIGH_ONES;
      end
      if (awAddrHeld == pwr_pkg::OFS_MSTLOW) begin
        mstLow <= wByte;
      end
    end
  end
  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= pwr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= isMapped(araddr) ? pwr_pkg::RESP_OKAY : pwr_pkg::RESP_SLVERR;
      case (araddr)
        pwr_pkg::OFS_SYSCTL: rdata <= {24'h0, sysCtl};
        pwr_pkg::OFS_MSTHIGH: rdata <= {24'h0, mstHigh};
        pwr_pkg::OFS_MSTLOW: rdata <= {24'h0, mstLow};
        pwr_pkg::OFS_STATUS: rdata <= {29'h0, state == pwr_pkg::ST_SETTLE,
                                       state == pwr_pkg::ST_SWSTBY,
                                       state == pwr_pkg::ST_SLEEP};
        default: rdata <= 32'h0;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  logic sleepWake;
  logic stbyWake;
  logic [18:0] settleCount;
  logic [18:0] selWait;
  // only enabled, unmasked sources (or NMI) may end sleep
  assign sleepWake = nmiReq || (irqReq && irqPeriphEnable && !irqMasked);
  assign stbyWake = nmiReq || (|(extIrqReq & extIrqEnable) && !irqMasked);

  function automatic logic [18:0] waitFor(input logic [2:0] code);
    case (code)
      3'h0: waitFor = WAIT_A;
      3'h1: waitFor = WAIT_B;
      3'h2: waitFor = WAIT_C;
      3'h3: waitFor = WAIT_D;
      3'h4: waitFor = WAIT_E;
      3'h5: waitFor = WAIT_F;
      3'h6: waitFor = WAIT_G;
      // illegal code: take the longest wait so the clock is never early
      default: waitFor = WAIT_F;
    endcase
  endfunction
  assign selWait = waitFor(sysCtl[pwr_pkg::BIT_SETTLE_HI:pwr_pkg::BIT_SETTLE_LO]);

  always_comb begin
    next_state = state;
    if (pinHwStby) begin
      next_state = pwr_pkg::ST_HWSTBY;
    end else if (pinReset) begin
      next_state = pwr_pkg::ST_RUN;
    end else begin
      case (state)
        pwr_pkg::ST_RUN: begin
          if (sleepExec) begin
            next_state = sysCtl[pwr_pkg::BIT_HW_STANDBY_PIN_SEL] ? pwr_pkg::ST_SWSTBY
                                                       : pwr_pkg::ST_SLEEP;
          end
        end
        pwr_pkg::ST_SLEEP: begin
          if (sleepWake) begin
            next_state = pwr_pkg::ST_RUN;
          end
        end
        pwr_pkg::ST_SWSTBY: begin
          if (stbyWake) begin
            next_state = pwr_pkg::ST_SETTLE;
          end
        end
        pwr_pkg::ST_SETTLE: begin
          if (settleCount == 19'h1) begin
            next_state = pwr_pkg::ST_RUN;
          end
        end
        pwr_pkg::ST_HWSTBY: next_state = pwr_pkg::ST_RUN;
        default: next_state = pwr_pkg::ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= pwr_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end
  // the wait is latched on wake so a later write cannot stretch it
  always_ff @(posedge clk) begin
    if (rst) begin
      settleCount <= 19'h0;
    end else if (state == pwr_pkg::ST_SWSTBY && next_state == pwr_pkg::ST_SETTLE) begin
      settleCount <= selWait;
    end else if (state == pwr_pkg::ST_SETTLE && settleCount != 19'h0) begin
      settleCount <= settleCount - 19'h1;
    end
  end
  // ----------------------------------------------------------------
  // outputs, all registered; state outputs from the next state and pins, standby bits from the registers
  // ----------------------------------------------------------------
  logic swStby;
  logic oeBit;
  assign swStby = (next_state == pwr_pkg::ST_SWSTBY) || (next_state == pwr_pkg::ST_SETTLE);
  assign oeBit = sysCtl[pwr_pkg::BIT_HW_STANDBY_PIN_OE];
  always_ff @(posedge clk) begin
    if (rst) begin
      cpuHalt <= 1'b0;
      oscRun <= 1'b1;
      chipClockRun <= 1'b1;
      periphReset <= 1'b0;
      irqHandleStart <= 1'b0;
      chipResetHold <= 1'b0;
      hwStandby <= 1'b0;
      addrBusOe <= 1'b1;
      busCtrlOe <= 1'b1;
      busCtrlForceHigh <= 1'b0;
    end else begin
      cpuHalt <= next_state != pwr_pkg::ST_RUN || pinReset;
      oscRun <= next_state != pwr_pkg::ST_SWSTBY && next_state != pwr_pkg::ST_HWSTBY;
      chipClockRun <= !swStby && next_state != pwr_pkg::ST_HWSTBY;
      periphReset <= swStby || next_state == pwr_pkg::ST_HWSTBY;
      irqHandleStart <= next_state == pwr_pkg::ST_RUN &&
                        (state == pwr_pkg::ST_SLEEP || state == pwr_pkg::ST_SETTLE) &&
                        !pinReset && !pinHwStby;
      chipResetHold <= pinReset && !pinHwStby;
      hwStandby <= next_state == pwr_pkg::ST_HWSTBY;
      addrBusOe <= next_state != pwr_pkg::ST_HWSTBY && (!swStby || oeBit);
      busCtrlOe <= next_state != pwr_pkg::ST_HWSTBY && (!swStby || oeBit);
      busCtrlForceHigh <= swStby && oeBit;
    end
  end
  // module standby bits stay in force in run, sleep and software standby; chip reset and hardware standby reinitialise them
  always_ff @(posedge clk) begin
    if (rst) begin
      sysClockOutEnable <= 1'b1;
      serial0Standby <= 1'b0;
      serial1Standby <= 1'b0;
      timer16Standby <= 1'b0;
      timer8Ch01Standby <= 1'b0;
      timer8Ch23Standby <= 1'b0;
      adcStandby <= 1'b0;
    end else begin
      sysClockOutEnable <= !mstHigh[pwr_pkg::BIT_CLK_STOP];
      serial1Standby <= mstHigh[pwr_pkg::BIT_SER1];
      serial0Standby <= mstHigh[pwr_pkg::BIT_SER0];
      timer16Standby <= mstLow[pwr_pkg::BIT_TMR16];
      timer8Ch01Standby <= mstLow[pwr_pkg::BIT_TMR8_01];
      timer8Ch23Standby <= mstLow[pwr_pkg::BIT_TMR8_23];
      adcStandby <= mstLow[pwr_pkg::BIT_ADC];
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_sleep_entry: assert property (
    state == pwr_pkg::ST_RUN && sleepExec && !sysCtl[7] && !pinReset && !pinHwStby
    |=> state == pwr_pkg::ST_SLEEP && cpuHalt)
    else $error("sleep not entered");
  chk_hw_standby_pin_entry: assert property (
    state == pwr_pkg::ST_RUN && sleepExec && sysCtl[7] && !pinReset && !pinHwStby
    |=> state == pwr_pkg::ST_SWSTBY ##1 (!chipClockRun && periphReset))
    else $error("software standby not entered");
  chk_select_kept: assert property (
    sysCtl[7] && !(wrLegal && awAddrHeld == pwr_pkg::OFS_SYSCTL) && !regInit
    |=> sysCtl[7])
    else $error("standby select lost");
  chk_settle_len: assert property (
    state == pwr_pkg::ST_SWSTBY && next_state == pwr_pkg::ST_SETTLE
    |=> settleCount == $past(selWait))
    else $error("settle count wrong");
  chk_float_bus: assert property (
    state == pwr_pkg::ST_SWSTBY && !oeBit && !regInit |=> !addrBusOe && !busCtrlOe)
    else $error("bus not floated");
  chk_hold_bus: assert property (
    state == pwr_pkg::ST_SWSTBY && oeBit && !regInit |=> addrBusOe && busCtrlForceHigh)
    else $error("bus not held");
  chk_fixed_ones: assert property (
    mstHigh[6:3] == 4'hf)
    else $error("fixed ones lost");
  chk_wake_irq: assert property (
    state == pwr_pkg::ST_SLEEP && sleepWake && !regInit |=> irqHandleStart && !cpuHalt)
    else $error("sleep wake missing");
  chk_masked_hold: assert property (
    state == pwr_pkg::ST_SLEEP && !nmiReq && irqMasked && !regInit
    |=> state == pwr_pkg::ST_SLEEP)
    else $error("masked irq woke sleep");
  chk_hw_hw_standby_pin: assert property (
    pinHwStby |=> state == pwr_pkg::ST_HWSTBY && mstHigh == pwr_pkg::MSTHIGH_RST)
    else $error("hardware standby missed");
  chk_clk_out: assert property (
    $rose(mstHigh[7]) |=> !sysClockOutEnable)
    else $error("clock output not stopped");

  cov_sleep_wake: cover property (state == pwr_pkg::ST_SLEEP ##1 state == pwr_pkg::ST_RUN);
  cov_settle_done: cover property (state == pwr_pkg::ST_SETTLE ##1 state == pwr_pkg::ST_RUN);
  cov_sleep_reset: cover property (state == pwr_pkg::ST_SLEEP && pinReset);
  cov_hw_standby_pin_hold: cover property (state == pwr_pkg::ST_SWSTBY && oeBit);
endmodule

//--- bench/cpu_side_model.sv
// behavioural cpu-side partner: issues sleep instructions, counts handler entries
`timescale 1ns/10ps
module cpu_side_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic sleepReq,
  input wire logic cpuHalt,
  input wire logic irqHandleStart,
  output logic sleepExec,
  output logic [7:0] startCount
);
  // ----------------------------------------------------------------
  // instruction issue
  // ----------------------------------------------------------------
  // a halted cpu fetches nothing, so no second sleep while halted
  always_ff @(posedge clk) begin
    if (rst) begin
      sleepExec <= 1'h0;
    end else begin
      sleepExec <= sleepReq && !sleepExec && !cpuHalt;
    end
  end
  // ----------------------------------------------------------------
  // handler entry count
  // ----------------------------------------------------------------
  // counting each high cycle exposes a pulse that lasts too long
  always_ff @(posedge clk) begin
    if (rst) begin
      startCount <= 8'h00;
    end else if (irqHandleStart) begin
      startCount <= startCount + 8'h01;
    end
  end
endmodule

//--- bench/power_down_ctrl_tb.sv
// self-checking bench for the power-down controller
`timescale 1ns/10ps
module power_down_ctrl_tb;
  // shortened settle waits; index 7 is the illegal code, taken as longest
  localparam logic [18:0] WAITS [8] = '{19'h8, 19'hc, 19'h10, 19'h14, 19'h18, 19'h1c, 19'h6, 19'h1c};
  logic clk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, nmiReq = 1'h0, irqReq = 1'h0, irqPeriphEnable = 1'h0;
  logic irqMasked = 1'h0, sleepReq = 1'h0, resetPinN = 1'h1, hwStandbyPinN = 1'h1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata;
  logic [2:0] extIrqReq = 3'h0, extIrqEnable = 3'h0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, sleepExec, cpuHalt, oscRun, chipClockRun;
  logic periphReset, irqHandleStart, chipResetHold, hwStandby, sysClockOutEnable;
  logic addrBusOe, busCtrlOe, busCtrlForceHigh, serial0Standby, serial1Standby;
  logic timer16Standby, timer8Ch01Standby, timer8Ch23Standby, adcStandby;
  logic [7:0] startCount;
  logic [15:0] lfsr = 16'hedd3;
  int bad_count = 0;
  int checks_done = 0;

  power_down_ctrl #(.WAIT_A(WAITS[0]), .WAIT_B(WAITS[1]), .WAIT_C(WAITS[2]), .WAIT_D(WAITS[3]),
    .WAIT_E(WAITS[4]), .WAIT_F(WAITS[5]), .WAIT_G(WAITS[6])) power_down_ctrl_inst (
    .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .sleepExec(sleepExec),
    .nmiReq(nmiReq), .irqReq(irqReq), .irqPeriphEnable(irqPeriphEnable), .irqMasked(irqMasked),
    .extIrqReq(extIrqReq), .extIrqEnable(extIrqEnable), .resetPinN(resetPinN),
    .hwStandbyPinN(hwStandbyPinN), .cpuHalt(cpuHalt), .oscRun(oscRun),
    .chipClockRun(chipClockRun), .periphReset(periphReset), .irqHandleStart(irqHandleStart),
    .chipResetHold(chipResetHold), .hwStandby(hwStandby), .sysClockOutEnable(sysClockOutEnable),
    .addrBusOe(addrBusOe), .busCtrlOe(busCtrlOe), .busCtrlForceHigh(busCtrlForceHigh),
    .serial0Standby(serial0Standby), .serial1Standby(serial1Standby),
    .timer16Standby(timer16Standby), .timer8Ch01Standby(timer8Ch01Standby),
    .timer8Ch23Standby(timer8Ch23Standby), .adcStandby(adcStandby));

  cpu_side_model cpu_side_model_inst (.clk(clk), .rst(rst), .sleepReq(sleepReq),
    .cpuHalt(cpuHalt), .irqHandleStart(irqHandleStart), .sleepExec(sleepExec),
    .startCount(startCount));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] next_rand(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // handshakes judged at mid-cycle, where they equal what the next edge samples
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] resp;
    b = 1'h0;
    awaddr <= a;
    wdata <= {lfsr, lfsr[7:0], d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      resp = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ar, r;
    logic [31:0] d;
    logic [1:0] resp;
    r = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!r) begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'h0;
    end
    chk("rdata", {24'h0, e}, d);
    chk("rresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic check_mst(input logic [7:0] h, input logic [7:0] l);
    chk1("sysClockOutEnable", !h[7], sysClockOutEnable);
    chk1("serial1Standby", h[1], serial1Standby);
    chk1("serial0Standby", h[0], serial0Standby);
    chk1("timer16Standby", l[4], timer16Standby);
    chk1("timer8Ch01Standby", l[3], timer8Ch01Standby);
    chk1("timer8Ch23Standby", l[2], timer8Ch23Standby);
    chk1("adcStandby", l[0], adcStandby);
  endtask

  task automatic sleep_now();
    sleepReq <= 1'h1;
    cyc(1);
    sleepReq <= 1'h0;
    cyc(4);
  endtask

  task automatic wait_start(input int lim, output int n);
    n = 0;
    @(negedge clk);
    while (irqHandleStart !== 1'h1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    int n;
    logic [7:0] h, l, s8, cnt;
    cyc(5);
    rst <= 1'h0;
    cyc(1);
    rd(pwr_pkg::OFS_SYSCTL, pwr_pkg::SYSCTL_RST, pwr_pkg::RESP_OKAY);
    rd(pwr_pkg::OFS_MSTHIGH, 8'h78, pwr_pkg::RESP_OKAY);
    rd(pwr_pkg::OFS_MSTLOW, 8'h00, pwr_pkg::RESP_OKAY);
    wr(4'h6, 8'hff, pwr_pkg::RESP_SLVERR);
    // lane 0 strobe low: the write is answered but must not land
    wstrb <= 4'he;
    wr(pwr_pkg::OFS_MSTLOW, 8'hff, pwr_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rd(pwr_pkg::OFS_MSTLOW, 8'h00, pwr_pkg::RESP_OKAY);
    rd(4'h6, 8'h00, pwr_pkg::RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      h = (i == 0) ? 8'h00 : lfsr[7:0];
      l = (i == 0) ? 8'hff : lfsr[15:8];
      wr(pwr_pkg::OFS_MSTHIGH, h, pwr_pkg::RESP_OKAY);
      wr(pwr_pkg::OFS_MSTLOW, l, pwr_pkg::RESP_OKAY);
      rd(pwr_pkg::OFS_MSTHIGH, (h & 8'h87) | 8'h78, pwr_pkg::RESP_OKAY);
      rd(pwr_pkg::OFS_MSTLOW, l, pwr_pkg::RESP_OKAY);
      check_mst(h, l);
    end
    cnt = startCount;
    sleep_now();
    chk1("cpuHalt", 1'h1, cpuHalt);
    chk1("chipClockRun", 1'h1, chipClockRun);
    check_mst(h, l);
    rd(pwr_pkg::OFS_STATUS, 8'h01, pwr_pkg::RESP_OKAY);
    irqReq <= 1'h1;
    irqMasked <= 1'h1;
    irqPeriphEnable <= 1'h1;
    cyc(8);
    chk1("cpuHalt", 1'h1, cpuHalt);
    irqMasked <= 1'h0;
    irqPeriphEnable <= 1'h0;
    cyc(8);
    chk1("cpuHalt", 1'h1, cpuHalt);
    irqPeriphEnable <= 1'h1;
    wait_start(20, n);
    chk("sleepWake", 32'h1, n);
    irqReq <= 1'h0;
    cyc(3);
    chk1("cpuHalt", 1'h0, cpuHalt);
    chk("startCount", {24'h0, cnt + 8'h01}, {24'h0, startCount});
    sleep_now();
    irqMasked <= 1'h1;
    nmiReq <= 1'h1;
    wait_start(20, n);
    chk("nmiWake", 32'h1, n);
    nmiReq <= 1'h0;
    irqMasked <= 1'h0;
    for (int c = 0; c < 8; c++) begin
      s8 = {1'h1, c[2:0], 2'h2, c[0], 1'h1};
      wr(pwr_pkg::OFS_SYSCTL, s8, pwr_pkg::RESP_OKAY);
      rd(pwr_pkg::OFS_SYSCTL, s8, pwr_pkg::RESP_OKAY);
      sleep_now();
      chk1("chipClockRun", 1'h0, chipClockRun);
      chk1("oscRun", 1'h0, oscRun);
      chk1("periphReset", 1'h1, periphReset);
      chk1("addrBusOe", c[0], addrBusOe);
      chk1("busCtrlOe", c[0], busCtrlOe);
      chk1("busCtrlForceHigh", c[0], busCtrlForceHigh);
      if (c == 0) begin
        extIrqReq <= 3'h1;
        cyc(10);
        chk1("chipClockRun", 1'h0, chipClockRun);
      end
      extIrqEnable <= 3'h7;
      extIrqReq <= 3'h1 << (c % 3);
      wait_start(60, n);
      chk1("settleWait", 1'h1, n >= WAITS[c] && n <= WAITS[c] + 19'h2);
      chk1("chipClockRun", 1'h1, chipClockRun);
      extIrqReq <= 3'h0;
      extIrqEnable <= 3'h0;
      rd(pwr_pkg::OFS_SYSCTL, s8, pwr_pkg::RESP_OKAY);
      rd(pwr_pkg::OFS_MSTLOW, l, pwr_pkg::RESP_OKAY);
      rd(pwr_pkg::OFS_MSTHIGH, (h & 8'h87) | 8'h78, pwr_pkg::RESP_OKAY);
    end
    wr(pwr_pkg::OFS_SYSCTL, 8'h09, pwr_pkg::RESP_OKAY);
    wr(pwr_pkg::OFS_MSTHIGH, 8'h87, pwr_pkg::RESP_OKAY);
    sleep_now();
    chk1("chipClockRun", 1'h1, chipClockRun);
    resetPinN <= 1'h0;
    cyc(8);
    chk1("chipResetHold", 1'h1, chipResetHold);
    resetPinN <= 1'h1;
    cyc(8);
    chk1("cpuHalt", 1'h0, cpuHalt);
    rd(pwr_pkg::OFS_MSTHIGH, 8'h78, pwr_pkg::RESP_OKAY);
    wr(pwr_pkg::OFS_MSTLOW, 8'hff, pwr_pkg::RESP_OKAY);
    sleep_now();
    hwStandbyPinN <= 1'h0;
    cyc(8);
    chk1("hwStandby", 1'h1, hwStandby);
    hwStandbyPinN <= 1'h1;
    cyc(8);
    rd(pwr_pkg::OFS_MSTLOW, 8'h00, pwr_pkg::RESP_OKAY);
    finish_test();
  end
endmodule
